//--- verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack, output_event;
    logic [7:0]  wb_adr = 8'h00, cell_cmd = 8'h00, pin_cmd = 8'h00, core_cmd = 8'h00;
    logic [7:0]  cell_out, pin_data, core_data;
    logic [31:0] wb_wdat = 32'h0, wb_rdat, rd;
    int          n_mismatch = 0, checks_done = 0;
    always #25 clock = ~clock;
    tdu_far_model i_far (.cell_cmd(cell_cmd), .pin_cmd(pin_cmd), .core_cmd(core_cmd),
        .cell_out(cell_out), .pin_data(pin_data), .core_data(core_data));
    tdu_top i_dut (.clock(clock), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .cell_out(cell_out), .pin_data(pin_data),
        .core_data(core_data), .output_event(output_event));
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_wdat <= d;
        @(posedge clock);
        while (wb_ack !== 1'b1 && n < 20) begin
            @(posedge clock);
            n++;
        end
        if (n == 20)
            n_mismatch++;
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clock);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_regs;
        bus(1'b0, 8'h00, 32'h0);
        check(rd, 32'h0);
        bus(1'b1, 8'h04, 32'h2300_0100);
        bus(1'b0, 8'h04, 32'h0);
        check(rd, 32'h2300_0100);
        bus(1'b1, 8'h14, 32'hFFFF_FFFF);
        bus(1'b0, 8'h14, 32'h0);
        check(rd, 32'h0);
        $display("test registers done");
    endtask
    // Step always high, limit from pin bus: must stop at 3, not run on
    task automatic t_count_up;
        pin_cmd <= 8'h03;
        bus(1'b1, 8'h00, 32'h0000_0107);
        bus(1'b1, 8'h08, 32'h0000_0000);
        bus(1'b1, 8'h0C, 32'h8000_0000);
        repeat (12) @(posedge clock);
        bus(1'b0, 8'h10, 32'h0);
        check(rd & 32'h3FF, 32'h103);
        check({31'h0, output_event}, 32'h1);
        $display("test count up done");
    endtask
    task automatic t_disable;
        bus(1'b1, 8'h0C, 32'h0);
        repeat (4) @(posedge clock);
        bus(1'b0, 8'h10, 32'h0);
        check(rd & 32'h3FF, 32'h200);
        $display("test disable done");
    endtask
    // Reload from cell 0 holds core value masked to two bits, then count down
    task automatic t_count_down;
        core_cmd <= 8'h0D;
        cell_cmd <= 8'h01;
        bus(1'b1, 8'h04, 32'h0100_0103);
        bus(1'b1, 8'h00, 32'h0000_0201);
        bus(1'b1, 8'h0C, 32'h8000_0000);
        bus(1'b0, 8'h10, 32'h0);
        check(rd & 32'hFF, 32'h0);
        repeat (8) @(posedge clock);
        bus(1'b0, 8'h10, 32'h0);
        check(rd & 32'h3FF, 32'h001);
        cell_cmd <= 8'h00;
        repeat (8) @(posedge clock);
        bus(1'b0, 8'h10, 32'h0);
        check(rd & 32'h3FF, 32'h100);
        $display("test count down done");
    endtask
    // Rotate at width 4, shift in aux at width 3, masked any, then compare
    task automatic t_shift;
        bus(1'b1, 8'h04, 32'h3305_0403);
        bus(1'b1, 8'h08, 32'h0000_0001);
        bus(1'b1, 8'h00, 32'h0000_0703);
        cell_cmd <= 8'h01;
        @(posedge clock);
        cell_cmd <= 8'h02;
        repeat (3) @(posedge clock);
        cell_cmd <= 8'h00;
        bus(1'b0, 8'h10, 32'h0);
        check(rd & 32'h3FF, 32'h002);
        bus(1'b1, 8'h00, 32'h0000_0A02);
        cell_cmd <= 8'h06;
        @(posedge clock);
        cell_cmd <= 8'h00;
        bus(1'b0, 8'h10, 32'h0);
        check(rd & 32'h3FF, 32'h105);
        bus(1'b1, 8'h00, 32'h0000_0902);
        cell_cmd <= 8'h06;
        repeat (2) @(posedge clock);
        bus(1'b0, 8'h10, 32'h0);
        check(rd & 32'h3FF, 32'h105);
        check({31'h0, output_event}, 32'h1);
        cell_cmd <= 8'h00;
        bus(1'b1, 8'h00, 32'h0000_0B02);
        bus(1'b0, 8'h10, 32'h0);
        check(rd & 32'h3FF, 32'h005);
        $display("test shift done");
    endtask
    // All triggers high: a held state must not move
    task automatic t_hold_codes;
        logic [3:0] codes [3] = '{4'h0, 4'hC, 4'hF};
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, 8'h00, {20'h0, codes[i], 8'h01});
            cell_cmd <= 8'h07;
            repeat (4) @(posedge clock);
            check({31'h0, output_event}, 32'h0);
            bus(1'b0, 8'h10, 32'h0);
            check(rd & 32'h3FF, 32'h005);
        end
        $display("test undefined codes done");
    endtask
    initial begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        t_regs;
        t_count_up;
        t_disable;
        t_count_down;
        t_shift;
        t_hold_codes;
        end_of_test;
    end
    initial begin
        #(50 * 2000);
        n_mismatch++;
        end_of_test;
    end
endmodule
`default_nettype wire

//--- verif/tdu_checker.sv
`timescale 1ns/1ps
`default_nettype none
module tdu_checker (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic [7:0]  cell_out,
    input wire logic [7:0]  pin_data,
    input wire logic [7:0]  core_data,
    input wire logic        output_event
);
    logic       take;
    logic       en_q;
    logic [3:0] opc_q;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // ----------------------------------------------------------------
    // Shadow of enable and opcode, so event rules need no internal probes
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            en_q  <= 1'b0;
            opc_q <= 4'h0;
        end else if (take && wb_we_i) begin
            if (wb_adr_i == 8'h0C && wb_sel_i[3])
                en_q <= wb_dat_i[31];
            if (wb_adr_i == 8'h00 && wb_sel_i[1])
                opc_q <= wb_dat_i[11:8];
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_ack_next: assert property (take |=> wb_ack_o) else $error("ack late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    a_ack_cause: assert property (wb_ack_o |-> $past(take)) else $error("ack without request");
    a_reset_quiet: assert property (disable iff (1'b0)
        rst |=> !wb_ack_o && !output_event && wb_dat_o == 32'h0) else $error("reset not quiet");
    a_dat_hold: assert property (!(take && !wb_we_i) |=> $stable(wb_dat_o))
        else $error("read data moved");
    a_unmapped_zero: assert property (take && !wb_we_i && wb_adr_i == 8'h14
        |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    a_disabled_quiet: assert property ((!en_q)[*3] |-> !output_event)
        else $error("event while disabled");
    a_undef_low: assert property ((opc_q == 4'h0 || opc_q > 4'hB)[*3] |-> !output_event)
        else $error("event under undefined code");
endmodule
bind tdu_top tdu_checker i_chk (.clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cell_out(cell_out),
    .pin_data(pin_data), .core_data(core_data), .output_event(output_event));
`default_nettype wire

//--- verif/tdu_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// Cells and buses are plain logic levels, always driven
module tdu_far_model (
    input wire logic  [7:0] cell_cmd,
    input wire logic  [7:0] pin_cmd,
    input wire logic  [7:0] core_cmd,
    output var logic  [7:0] cell_out,
    output var logic  [7:0] pin_data,
    output var logic  [7:0] core_data
);
    assign cell_out  = cell_cmd;
    assign pin_data  = pin_cmd;
    assign core_data = core_cmd;
endmodule
`default_nettype wire

//--- verilog/tdu_operand_mux.v
`timescale 1ns/1ps
`default_nettype none
`include "tdu_regs.vh"

module tdu_operand_mux (
    input  wire [1:0] sel,
    input  wire [7:0] core_data,
    input  wire [7:0] pin_data,
    input  wire [7:0] soft_data,
    output reg  [7:0] operand
);
    always @* begin
        case (sel)
            `TDU_OPND_ZERO: operand = 8'h00;
            `TDU_OPND_CORE: operand = core_data;
            `TDU_OPND_PIN:  operand = pin_data;
            default:        operand = soft_data;
        endcase
    end
endmodule
`default_nettype wire

//--- verilog/tdu_regs.vh
`ifndef TDU_REGS_VH
`define TDU_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TDU_OFS_UNIT_CONTROL       8'h00
`define TDU_OFS_UNIT_SOURCE_SELECT 8'h04
`define TDU_OFS_UNIT_OPERAND_VALUE 8'h08
`define TDU_OFS_BLOCK_CONTROL      8'h0C
`define TDU_OFS_UNIT_STATUS        8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TDU_WIDTH_LSB       0
`define TDU_WIDTH_MSB       2
`define TDU_OPCODE_LSB      8
`define TDU_OPCODE_MSB      11
`define TDU_RELOAD_SEL_LSB  0
`define TDU_RELOAD_SEL_MSB  3
`define TDU_STEP_SEL_LSB    8
`define TDU_STEP_SEL_MSB    11
`define TDU_AUX_SEL_LSB     16
`define TDU_AUX_SEL_MSB     19
`define TDU_INIT_SEL_LSB    24
`define TDU_INIT_SEL_MSB    25
`define TDU_LIMIT_SEL_LSB   28
`define TDU_LIMIT_SEL_MSB   29
`define TDU_OPERAND_LSB     0
`define TDU_OPERAND_MSB     7
`define TDU_ENABLE_BIT      31
`define TDU_STAT_EVENT_BIT  8
`define TDU_STAT_RESET_BIT  9

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TDU_RST_UNIT_CONTROL       32'h0000_0000
`define TDU_RST_UNIT_SOURCE_SELECT 32'h0000_0000
`define TDU_RST_UNIT_OPERAND_VALUE 32'h0000_0000
`define TDU_RST_BLOCK_CONTROL      32'h0000_0000

// ----------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------
`define TDU_OP_COUNT_UP        4'h1
`define TDU_OP_COUNT_DOWN      4'h2
`define TDU_OP_COUNT_UP_WRAP   4'h3
`define TDU_OP_COUNT_DOWN_WRAP 4'h4
`define TDU_OP_UP_DOWN         4'h5
`define TDU_OP_UP_DOWN_WRAP    4'h6
`define TDU_OP_ROTATE_RIGHT    4'h7
`define TDU_OP_SHIFT_RIGHT     4'h8
`define TDU_OP_MASKED_ANY      4'h9
`define TDU_OP_SHIFT_MAJORITY  4'hA
`define TDU_OP_SHIFT_COMPARE   4'hB

// ----------------------------------------------------------------
// Trigger and operand source codes, timing
// ----------------------------------------------------------------
`define TDU_TRIG_LOW       4'h0
`define TDU_TRIG_HIGH      4'h1
`define TDU_TRIG_FEEDBACK  4'h2
`define TDU_TRIG_CELL_LO   4'h3
`define TDU_TRIG_CELL_HI   4'hA
`define TDU_OPND_ZERO      2'h0
`define TDU_OPND_CORE      2'h1
`define TDU_OPND_PIN       2'h2
`define TDU_OPND_SOFTWARE  2'h3
`define TDU_RELEASE_CYCLES 2'h3

`endif

//--- verilog/tdu_top.v
// Behaviour
// - Four-bit operation code picks one of eleven operations, codes 1 to 11.
// - Active width is the three-bit width field plus one.
// - Reload trigger source: 0 low, 1 high, 2 own event, 3..10 cells 0..7.
// - Step and auxiliary triggers use own selects at 11:8 and 19:16.
// - Each operand comes from zero, pin bus, core bus or software field.
// - Initial operand select at 25:24, limit operand select at 29:28.
// - One output event; 8-bit state held in unit-clock flip-flops.
// - Mask of width bits drives the limit and zero compares, increment, decrement and masked operand.
// - Count up: reload loads, step increments to limit then holds.
// - Count up wrap: step at limit reloads initial operand.
// - Count down: reload loads, step decrements to zero then holds.
// - Count down wrap: step at zero reloads initial operand.
// - Up/down: reload, then step up to limit, then aux down to zero.
// - Up/down wrap: step at limit or aux at zero reloads initial operand.
// - Rotate right: old lsb goes to top of active width; event is lsb.
// - Shift right: aux trigger enters top of active width; event is lsb.
// - Shift majority shifts as shift; event high for state 3, 5, 6, 7.
// - Shift compare shifts as shift; event is masked state equals masked limit.
// - Masked any: event is OR of the bits of state AND limit AND mask; only reload changes.
// - Disabled block holds state in reset; release three cycles after enable.
//
// Register access over Wishbone and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "tdu_regs.vh"

module tdu_top (
    input  wire        clock,
    input  wire        rst,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire [7:0]  cell_out,
    input  wire [7:0]  pin_data,
    input  wire [7:0]  core_data,
    output reg         output_event
);

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    reg  [31:0] unit_control_q;
    reg  [31:0] unit_source_select_q;
    reg  [31:0] unit_operand_value_q;
    reg  [31:0] block_control_q;
    reg  [31:0] rd_data_d;
    wire        bus_req;
    wire        wr_req;
    wire [31:0] lane_mask;

    // One access per request cycle; the gap after ack only masks the ack cycle, so a held
    // stb is taken again on the cycle after.
    assign bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_req    = bus_req & wb_we_i;
    assign lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                        {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    always @(posedge clock) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    always @(posedge clock) begin
        if (rst) begin
            unit_control_q       <= `TDU_RST_UNIT_CONTROL;
            unit_source_select_q <= `TDU_RST_UNIT_SOURCE_SELECT;
            unit_operand_value_q <= `TDU_RST_UNIT_OPERAND_VALUE;
            block_control_q      <= `TDU_RST_BLOCK_CONTROL;
        end else if (wr_req) begin
            if (wb_adr_i == `TDU_OFS_UNIT_CONTROL) begin
                unit_control_q <= (unit_control_q & ~lane_mask) | (wb_dat_i & lane_mask);
            end else if (wb_adr_i == `TDU_OFS_UNIT_SOURCE_SELECT) begin
                unit_source_select_q <= (unit_source_select_q & ~lane_mask)
                                        | (wb_dat_i & lane_mask);
            end else if (wb_adr_i == `TDU_OFS_UNIT_OPERAND_VALUE) begin
                unit_operand_value_q <= (unit_operand_value_q & ~lane_mask)
                                        | (wb_dat_i & lane_mask);
            end else if (wb_adr_i == `TDU_OFS_BLOCK_CONTROL) begin
                block_control_q <= (block_control_q & ~lane_mask) | (wb_dat_i & lane_mask);
            end
        end
    end

    // ----------------------------------------------------------------
    // Field extraction
    // ----------------------------------------------------------------
    wire [2:0] width_minus_one;
    wire [3:0] operation_code;
    wire [3:0] reload_trigger_select;
    wire [3:0] step_trigger_select;
    wire [3:0] aux_trigger_select;
    wire [1:0] initial_operand_select;
    wire [1:0] limit_operand_select;
    wire [7:0] soft_operand;
    wire       block_enable;

    assign width_minus_one        = unit_control_q[`TDU_WIDTH_MSB:`TDU_WIDTH_LSB];
    assign operation_code         = unit_control_q[`TDU_OPCODE_MSB:`TDU_OPCODE_LSB];
    assign reload_trigger_select  =
        unit_source_select_q[`TDU_RELOAD_SEL_MSB:`TDU_RELOAD_SEL_LSB];
    assign step_trigger_select    =
        unit_source_select_q[`TDU_STEP_SEL_MSB:`TDU_STEP_SEL_LSB];
    assign aux_trigger_select     =
        unit_source_select_q[`TDU_AUX_SEL_MSB:`TDU_AUX_SEL_LSB];
    assign initial_operand_select =
        unit_source_select_q[`TDU_INIT_SEL_MSB:`TDU_INIT_SEL_LSB];
    assign limit_operand_select   =
        unit_source_select_q[`TDU_LIMIT_SEL_MSB:`TDU_LIMIT_SEL_LSB];
    assign soft_operand           = unit_operand_value_q[`TDU_OPERAND_MSB:`TDU_OPERAND_LSB];
    assign block_enable           = block_control_q[`TDU_ENABLE_BIT];

    // ----------------------------------------------------------------
    // Block reset release
    // ----------------------------------------------------------------
    reg  [1:0] release_cnt_q;
    wire       unit_reset;

    // Held in reset while disabled; the delay keeps the state in reset
    // for three cycles after enable before it may move.
    always @(posedge clock) begin
        if (rst || !block_enable) begin
            release_cnt_q <= 2'h0;
        end else if (release_cnt_q != `TDU_RELEASE_CYCLES) begin
            release_cnt_q <= release_cnt_q + 2'h1;
        end
    end

    assign unit_reset = (release_cnt_q != `TDU_RELEASE_CYCLES);

    // ----------------------------------------------------------------
    // Trigger and operand selection
    // ----------------------------------------------------------------
    reg        event_d;
    wire       reload_trigger;
    wire       step_trigger;
    wire       aux_trigger;
    wire [7:0] initial_operand;
    wire [7:0] limit_operand;

    // Feedback uses the unregistered event; it depends on state, limit operand and register fields only,
    // so no combinational loop through the trigger path is possible.
    tdu_trigger_mux u_reload_mux (
        .sel       (reload_trigger_select),
        .own_event (event_d),
        .cell_out  (cell_out),
        .trig      (reload_trigger)
    );

    tdu_trigger_mux u_step_mux (
        .sel       (step_trigger_select),
        .own_event (event_d),
        .cell_out  (cell_out),
        .trig      (step_trigger)
    );

    tdu_trigger_mux u_aux_mux (
        .sel       (aux_trigger_select),
        .own_event (event_d),
        .cell_out  (cell_out),
        .trig      (aux_trigger)
    );

    tdu_operand_mux u_initial_mux (
        .sel       (initial_operand_select),
        .core_data (core_data),
        .pin_data  (pin_data),
        .soft_data (soft_operand),
        .operand   (initial_operand)
    );

    tdu_operand_mux u_limit_mux (
        .sel       (limit_operand_select),
        .core_data (core_data),
        .pin_data  (pin_data),
        .soft_data (soft_operand),
        .operand   (limit_operand)
    );

    // ----------------------------------------------------------------
    // Shared datapath terms
    // ----------------------------------------------------------------
    reg  [7:0] state_register_q;
    reg  [7:0] state_register_d;
    wire [7:0] mask;
    wire [7:0] top_bit;
    wire [7:0] init_masked;
    wire       eq_limit;
    wire       eq_zero;
    wire [7:0] incr_masked;
    wire [7:0] decr_masked;
    wire [7:0] shifted;
    wire [7:0] rotated;
    wire [7:0] shifted_in;
    wire       majority;

    assign mask        = 8'hFF >> (3'h7 - width_minus_one);
    assign top_bit     = 8'h01 << width_minus_one;
    assign init_masked = initial_operand & mask;
    assign eq_limit    = (state_register_q & mask) == (limit_operand & mask);
    assign eq_zero     = (state_register_q & mask) == 8'h00;
    assign incr_masked = (state_register_q + 8'h01) & mask;
    assign decr_masked = (state_register_q - 8'h01) & mask;
    // Top position cleared, so a stale bit left above a narrowed width cannot leak in
    assign shifted     = {1'b0, state_register_q[7:1]} & mask & ~top_bit;
    assign rotated     = shifted | (state_register_q[0] ? top_bit : 8'h00);
    assign shifted_in  = shifted | (aux_trigger ? top_bit : 8'h00);
    // Compared against the whole state, so bits above the width must be clear
    assign majority    = (state_register_q == 8'h03) | (state_register_q == 8'h05)
                         | (state_register_q == 8'h06) | (state_register_q == 8'h07);

    // ----------------------------------------------------------------
    // Operation select
    // ----------------------------------------------------------------
    always @* begin
        state_register_d = state_register_q;
        event_d          = 1'b0;
        case (operation_code)
            `TDU_OP_COUNT_UP: begin
                event_d = eq_limit;
                if (reload_trigger) begin
                    state_register_d = init_masked;
                end else if (step_trigger) begin
                    state_register_d = eq_limit ? state_register_q : incr_masked;
                end
            end
            `TDU_OP_COUNT_UP_WRAP: begin
                event_d = eq_limit;
                if (reload_trigger) begin
                    state_register_d = init_masked;
                end else if (step_trigger) begin
                    state_register_d = eq_limit ? init_masked : incr_masked;
                end
            end
            `TDU_OP_COUNT_DOWN: begin
                event_d = eq_zero;
                if (reload_trigger) begin
                    state_register_d = init_masked;
                end else if (step_trigger) begin
                    state_register_d = eq_zero ? state_register_q : decr_masked;
                end
            end
            `TDU_OP_COUNT_DOWN_WRAP: begin
                event_d = eq_zero;
                if (reload_trigger) begin
                    state_register_d = init_masked;
                end else if (step_trigger) begin
                    state_register_d = eq_zero ? init_masked : decr_masked;
                end
            end
            `TDU_OP_UP_DOWN: begin
                event_d = eq_limit | eq_zero;
                if (reload_trigger) begin
                    state_register_d = init_masked;
                end else if (step_trigger) begin
                    state_register_d = eq_limit ? state_register_q : incr_masked;
                end else if (aux_trigger) begin
                    state_register_d = eq_zero ? state_register_q : decr_masked;
                end
            end
            `TDU_OP_UP_DOWN_WRAP: begin
                event_d = eq_limit | eq_zero;
                if (reload_trigger) begin
                    state_register_d = init_masked;
                end else if (step_trigger) begin
                    state_register_d = eq_limit ? init_masked : incr_masked;
                end else if (aux_trigger) begin
                    state_register_d = eq_zero ? init_masked : decr_masked;
                end
            end
            `TDU_OP_ROTATE_RIGHT: begin
                event_d = state_register_q[0];
                if (reload_trigger) begin
                    state_register_d = init_masked;
                end else if (step_trigger) begin
                    state_register_d = rotated;
                end
            end
            `TDU_OP_SHIFT_RIGHT: begin
                event_d = state_register_q[0];
                if (reload_trigger) begin
                    state_register_d = init_masked;
                end else if (step_trigger) begin
                    state_register_d = shifted_in;
                end
            end
            `TDU_OP_MASKED_ANY: begin
                event_d = |(state_register_q & limit_operand & mask);
                if (reload_trigger) begin
                    state_register_d = init_masked;
                end
            end
            `TDU_OP_SHIFT_MAJORITY: begin
                event_d = majority;
                if (reload_trigger) begin
                    state_register_d = init_masked;
                end else if (step_trigger) begin
                    state_register_d = shifted_in;
                end
            end
            `TDU_OP_SHIFT_COMPARE: begin
                event_d = eq_limit;
                if (reload_trigger) begin
                    state_register_d = init_masked;
                end else if (step_trigger) begin
                    state_register_d = shifted_in;
                end
            end
            default: begin
                state_register_d = state_register_q;
                event_d          = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // State and event flip-flops
    // ----------------------------------------------------------------
    // The event port is registered, so it trails the state by one cycle;
    // this matches running the unit with its output pipelined.
    always @(posedge clock) begin
        if (rst || unit_reset) begin
            state_register_q <= 8'h00;
            output_event     <= 1'b0;
        end else begin
            state_register_q <= state_register_d;
            output_event     <= event_d;
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    always @* begin
        if (wb_adr_i == `TDU_OFS_UNIT_CONTROL) begin
            rd_data_d = unit_control_q;
        end else if (wb_adr_i == `TDU_OFS_UNIT_SOURCE_SELECT) begin
            rd_data_d = unit_source_select_q;
        end else if (wb_adr_i == `TDU_OFS_UNIT_OPERAND_VALUE) begin
            rd_data_d = unit_operand_value_q;
        end else if (wb_adr_i == `TDU_OFS_BLOCK_CONTROL) begin
            rd_data_d = block_control_q;
        end else if (wb_adr_i == `TDU_OFS_UNIT_STATUS) begin
            rd_data_d = {22'h0, unit_reset, event_d, state_register_q};
        end else begin
            rd_data_d = 32'h0000_0000;
        end
    end

    always @(posedge clock) begin
        if (rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_req && !wb_we_i) begin
            wb_dat_o <= rd_data_d;
        end
    end

endmodule
`default_nettype wire

//--- verilog/tdu_trigger_mux.v
`timescale 1ns/1ps
`default_nettype none
`include "tdu_regs.vh"

module tdu_trigger_mux (
    input  wire [3:0] sel,
    input  wire       own_event,
    input  wire [7:0] cell_out,
    output reg        trig
);
    wire [3:0] cell_idx;

    assign cell_idx = sel - `TDU_TRIG_CELL_LO;

    always @* begin
        if (sel == `TDU_TRIG_LOW) begin
            trig = 1'b0;
        end else if (sel == `TDU_TRIG_HIGH) begin
            trig = 1'b1;
        end else if (sel == `TDU_TRIG_FEEDBACK) begin
            trig = own_event;
        end else if (sel <= `TDU_TRIG_CELL_HI) begin
            // Codes 3..10 pick cells 0..7
            trig = cell_out[cell_idx[2:0]];
        end else begin
            // Undefined codes read as a quiet low trigger
            trig = 1'b0;
        end
    end
endmodule
`default_nettype wire
